// ==== core/pwc_pkg.sv ====
// Package for the PWM wave counter: register map, field layout, reset values and states.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses.
// Operation
// - One shared 15-bit counter feeds four channels.
// - Parameter bit 15 selects channel polarity.
// - Mode register selects up or up-down counting.
// - Period top and prescaler set PWM period.
// - Top below compare: no edges, falling-first high.
// - Compare registers loaded only by sequence decoder.
// - Period top writable anytime, sampled at period ends.
// - Load mode load_a uses RAM top value.
// - Other modes sample top on start, loads and every period end.
// - Up mode wraps at top; outputs invert there.
// - Falling-first: compare zero low, compare top high.
// - Up mode pulses are edge-aligned at wrap.
// - Up period is top base clocks.
// - Up-down reverses at top; center-aligned pulses.
// - Up-down period is twice top base clocks.
// - Four channel outputs drive assigned GPIO pins.
// - Parameter splits into polarity and 15-bit compare.
// - Idle start fetches first value then counts.
// - Stop in run ends period, idles pins, raises halted.
package pwc_pkg;
    localparam int PWC_CW = 15;
    localparam int PWC_NCH = 4;
    localparam logic [7:0] PWC_OFF_TOP = 8'h00;
    localparam logic [7:0] PWC_OFF_MODE = 8'h04;
    localparam logic [7:0] PWC_OFF_PRESC = 8'h08;
    localparam logic [7:0] PWC_OFF_LOAD = 8'h0C;
    localparam logic [7:0] PWC_OFF_STAT = 8'h10;
    localparam logic [14:0] PWC_TOP_RST = 15'h03E8;
    localparam logic [2:0] PWC_PRESC_RST = 3'h0;
    localparam int PWC_POL_BIT = 15;
    localparam logic [1:0] PWC_LOAD_A = 2'h3;
    typedef enum logic [1:0] {PWC_IDLE = 2'b00, PWC_FETCH = 2'b01, PWC_RUN = 2'b11, PWC_STOP = 2'b10} pwc_state_t;
    typedef struct packed {
        logic pol;
        logic [14:0] cmp;
    } pwc_param_t;
endpackage

// ==== core/pwc_chan.sv ====
`timescale 1ns/1ns
// One compare channel: turns counter value, compare and polarity into a pin level.
// Assumes count, top and direction come from the shared counter in the same clock.
module pwc_chan
    import pwc_pkg::*;
(
    input wire logic [14:0] count,
    input wire logic [14:0] top,
    input wire pwc_param_t prm,
    output logic level
);
    // Active phase is count below compare in both modes; in up-down the down leg mirrors it, giving centred pulses.
    // Compare 0 never active, compare >= top always active, so no edges appear.
    logic active;
    always_comb
    begin
        active = (prm.cmp > top) ? 1'b1 : (count < prm.cmp);
        level = prm.pol ? active : ~active;
    end
endmodule // pwc_chan

// ==== core/pwc_wave_counter.sv ====
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
// Wave counter top level: Wishbone registers, prescaler, shared counter, sequencer and four channels.
// Assumes the decoder presents one parameter per channel with a one-cycle valid strobe.
module pwc_wave_counter
    import pwc_pkg::*;
#(
    parameter int NCH = PWC_NCH
)
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic sequence_start_task,
    input wire logic stop_task,
    output logic fetch_req,
    input wire logic dec_valid,
    input wire pwc_param_t [NCH-1:0] dec_param,
    input wire logic [14:0] dec_top,
    input wire logic [NCH-1:0] gpio_idle,
    output logic [NCH-1:0] channel_output,
    output logic halted_event,
    output logic period_end
);
    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    logic [14:0] period_top_r;
    logic mode_r;
    logic [2:0] presc_r;
    logic [1:0] load_sel_r;
    logic running;
    pwc_state_t state_r;
    logic [14:0] cnt_r;
    logic ack_r;
    logic wr;
    // The write lands at the edge where the master samples ack high, so it never lands before the answer.
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
    assign wb_ack_o = ack_r;

    // One registered ack per request after one wait state; dropped in the cycle after.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ack_r <= 1'b0;
        else if (clk_en)
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end

    // Software-writable settings; compare values have no address at all. Top writes are safe anytime.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            period_top_r <= PWC_TOP_RST;
            mode_r <= 1'b0;
            presc_r <= PWC_PRESC_RST;
            load_sel_r <= 2'h0;
        end
        else if (clk_en && wr)
        begin
            case (wb_adr_i)
                PWC_OFF_TOP: period_top_r <= wb_dat_i[14:0];
                PWC_OFF_MODE: mode_r <= wb_dat_i[0];
                PWC_OFF_PRESC: presc_r <= wb_dat_i[2:0];
                PWC_OFF_LOAD: load_sel_r <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped offsets read zero.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (clk_en)
        begin
            case (wb_adr_i)
                PWC_OFF_TOP: wb_dat_o <= {17'h0_0000, period_top_r};
                PWC_OFF_MODE: wb_dat_o <= {31'h0000_0000, mode_r};
                PWC_OFF_PRESC: wb_dat_o <= {29'h0000_0000, presc_r};
                PWC_OFF_LOAD: wb_dat_o <= {30'h0000_0000, load_sel_r};
                PWC_OFF_STAT: wb_dat_o <= {14'h0000, cnt_r, running, state_r};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic [7:0] pre_r;
    logic tick;
    assign running = (state_r == PWC_RUN) || (state_r == PWC_STOP);
    assign tick = running && (pre_r == ((8'h01 << presc_r) - 8'h01));

    // Divides ref_clk by 2^presc to make the PWM base clock enable.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            pre_r <= 8'h00;
        else if (clk_en)
            pre_r <= (!running || tick) ? 8'h00 : pre_r + 8'h01;
    end

    // ------------------------------------------------------------
    // Shared counter and active settings
    // ------------------------------------------------------------
    logic down_r;
    logic [14:0] top_act_r;
    logic mode_act_r;
    logic wrap;
    pwc_param_t [NCH-1:0] prm_r;
    // Period ends at top in up mode, at the return to zero in up-down mode.
    assign wrap = tick && (mode_act_r ? (down_r && cnt_r <= 15'h0001) : (cnt_r >= top_act_r - 15'h0001));
    assign period_end = wrap;

    // One 15-bit counter for all channels.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 15'h0000;
            down_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!running)
            begin
                cnt_r <= 15'h0000;
                down_r <= 1'b0;
            end
            else if (wrap)
            begin
                cnt_r <= 15'h0000;
                down_r <= 1'b0;
            end
            else if (tick && mode_act_r && !down_r && cnt_r >= top_act_r - 15'h0001)
            begin
                cnt_r <= top_act_r;
                down_r <= 1'b1;
            end
            else if (tick)
                cnt_r <= down_r ? cnt_r - 15'h0001 : cnt_r + 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // Sequencer: start, fetch, run, stop
    // ------------------------------------------------------------
    logic take;
    assign take = dec_valid && ((state_r == PWC_FETCH) || (state_r == PWC_RUN && wrap));
    assign fetch_req = (state_r == PWC_FETCH) || (state_r == PWC_RUN);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= PWC_IDLE;
            halted_event <= 1'b0;
        end
        else if (clk_en)
        begin
            halted_event <= 1'b0;
            case (state_r)
                PWC_IDLE: if (sequence_start_task) state_r <= PWC_FETCH;
                PWC_FETCH: if (stop_task) state_r <= PWC_IDLE;
                           else if (dec_valid) state_r <= PWC_RUN;
                PWC_RUN: if (stop_task) state_r <= PWC_STOP;
                PWC_STOP: if (wrap)
                begin
                    state_r <= PWC_IDLE;
                    halted_event <= 1'b1;
                end
                default: state_r <= PWC_IDLE;
            endcase
        end
    end

    // Compare is latched only on decoder loads; top and mode also at every period end in run (top only on loads in load_a).
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prm_r <= '0;
            top_act_r <= PWC_TOP_RST;
            mode_act_r <= 1'b0;
        end
        else if (clk_en && (take || (state_r == PWC_RUN && wrap)))
        begin
            if (take)
                prm_r <= dec_param;
            // In load_a the decoder top is only valid with its strobe, so a plain period end keeps the old top.
            if (load_sel_r == PWC_LOAD_A)
            begin
                if (take)
                    top_act_r <= dec_top;
            end
            else
                top_act_r <= period_top_r;
            mode_act_r <= mode_r;
        end
    end

    // ------------------------------------------------------------
    // Channels and pins
    // ------------------------------------------------------------
    logic [NCH-1:0] lvl;
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        pwc_chan u_ch (
            // The down leg is shown one step lower, so each leg is active for cmp steps and duty moves by two.
            .count(down_r ? cnt_r - 15'h0001 : cnt_r),
            .top(top_act_r),
            .prm(prm_r[i]),
            .level(lvl[i])
        );
    end

    // Registered pins; idle shows the GPIO level.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            channel_output <= '0;
        else if (clk_en)
            channel_output <= running ? lvl : gpio_idle;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_halt_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        halted_event |-> state_r == PWC_IDLE)
        else $error("halted without idle");
    chk_cnt_top: assert property (@(posedge ref_clk) disable iff (!arst_n)
        running && top_act_r != 15'h0000 |-> cnt_r <= top_act_r)
        else $error("counter above top");
    chk_idle_pins: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && !running |=> channel_output == $past(gpio_idle))
        else $error("idle pins wrong");
    chk_wrap_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && wrap && state_r == PWC_RUN |=> cnt_r == 15'h0000)
        else $error("no wrap to zero");
    chk_start_fetch: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && state_r == PWC_IDLE && sequence_start_task |=> state_r == PWC_FETCH)
        else $error("start not fetching");
    chk_top_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && take && load_sel_r == PWC_LOAD_A |=> top_act_r == $past(dec_top))
        else $error("load_a top wrong");
    chk_top_sw: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && take && load_sel_r != PWC_LOAD_A |=> top_act_r == $past(period_top_r))
        else $error("top not sampled");
    chk_ack_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en && wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    cov_updown: cover property (@(posedge ref_clk) disable iff (!arst_n) down_r && wrap);
    cov_halt: cover property (@(posedge ref_clk) disable iff (!arst_n) halted_event);
    cov_loada: cover property (@(posedge ref_clk) disable iff (!arst_n) take && load_sel_r == PWC_LOAD_A);
endmodule // pwc_wave_counter

// ==== sim/pwc_dec_model.sv ====
`timescale 1ns/1ns
// Decoder stand-in: hands over one parameter set for each rising fetch request.
// Assumes the bench holds prm, top and lat steady while a start is pending.
module pwc_dec_model
    import pwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic fetch_req,
    input wire logic [3:0] lat,
    input wire pwc_param_t [PWC_NCH-1:0] prm,
    input wire logic [14:0] top,
    output logic dec_valid,
    output pwc_param_t [PWC_NCH-1:0] dec_param,
    output logic [14:0] dec_top
);
    // Lines carry the inverse outside the strobe, so a late sample shows up.
    initial
    begin
        dec_valid = 1'b0;
        forever
        begin
            @(posedge fetch_req);
            @(posedge ref_clk);
            repeat (lat) @(posedge ref_clk);
            dec_valid <= 1'b1;
            dec_param <= prm;
            dec_top <= top;
            @(posedge ref_clk);
            dec_valid <= 1'b0;
            dec_param <= ~prm;
            dec_top <= ~top;
        end
    end
endmodule // pwc_dec_model

// ==== sim/tb.sv ====
`timescale 1ns/1ns
// Bench for pwc_wave_counter: bus, start, period, duty, top reload and stop.
// Assumes pwc_dec_model answers fetches; the clock runs at 20 MHz.
module tb
    import pwc_pkg::*;
;
    typedef struct {int per; int hi[PWC_NCH];} pwc_note_t;
    logic ref_clk = 1'b0, arst_n = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic sequence_start_task = 1'b0, stop_task = 1'b0, fetch_req, dec_valid, wb_ack_o, halted_event, period_end;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic [3:0] lat = 4'h0, gpio_idle = 4'h0, channel_output;
    logic [14:0] dec_top, m_top = 15'h0000;
    pwc_param_t [PWC_NCH-1:0] dec_param, m_prm = '0;
    logic [31:0] rd_q[$];
    pwc_note_t exp_q[$];
    int err_count = 0, n_tests = 0, ncyc = 0, nhi[PWC_NCH] = '{default:0};
    always #25 ref_clk = ~ref_clk;
    pwc_wave_counter dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sequence_start_task(sequence_start_task),
        .stop_task(stop_task), .fetch_req(fetch_req), .dec_valid(dec_valid), .dec_param(dec_param),
        .dec_top(dec_top), .gpio_idle(gpio_idle), .channel_output(channel_output),
        .halted_event(halted_event), .period_end(period_end));
    pwc_dec_model dec (.ref_clk(ref_clk), .fetch_req(fetch_req), .lat(lat), .prm(m_prm), .top(m_top),
        .dec_valid(dec_valid), .dec_param(dec_param), .dec_top(dec_top));
    // -----------------------------------------------------------------
    // Checking
    // -----------------------------------------------------------------
    task automatic tally(input bit ok, input string what);
        n_tests++;
        if (!ok)
        begin
            err_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] want);
        tally(wb_dat_o === want, "read data");
    endtask
    task automatic cmp_per(input pwc_note_t e);
        tally(ncyc == e.per, "period length");
        for (int i = 0; i < PWC_NCH; i++)
            if (e.hi[i] >= 0) tally(nhi[i] == e.hi[i], "high time");
    endtask
    task automatic cmp_idle();
        tally(channel_output === gpio_idle, "idle pins");
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // A window spans two period ends; the pin lag does not matter for a periodic wave.
    always @(posedge ref_clk)
    begin
        if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0) cmp_rd(rd_q.pop_front());
        ncyc++;
        for (int i = 0; i < PWC_NCH; i++)
            if (channel_output[i] === 1'b1) nhi[i]++;
        if (period_end === 1'b1)
        begin
            if (exp_q.size() > 0) cmp_per(exp_q.pop_front());
            ncyc = 0;
            nhi = '{default:0};
        end
    end
    // -----------------------------------------------------------------
    // Stimulus
    // -----------------------------------------------------------------
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] want);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        if (!we) rd_q.push_back(want);
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) tally(0, "no bus answer");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Lets settings land for a few periods, then notes the expected window.
    task automatic settle_check(input int md, input int ps, input int t);
        pwc_note_t e;
        repeat (3) @(posedge ref_clk iff period_end === 1'b1);
        @(negedge ref_clk);
        e.per = (t << ps) << md;
        foreach (e.hi[i])
        begin
            e.hi[i] = (m_prm[i].cmp > t) ? e.per : ((m_prm[i].cmp << ps) << md);
            if (e.hi[i] >= 0 && !m_prm[i].pol) e.hi[i] = e.per - e.hi[i];
        end
        exp_q.push_back(e);
        wait (exp_q.size() == 0);
        @(posedge ref_clk);
    endtask
    task automatic run_cfg(input int md, input int ps, input int ld, input int tp, input int tp2);
        int dt;
        dt = $urandom_range(20, 6);
        m_top <= 15'(dt);
        lat <= 4'($urandom_range(5, 0));
        gpio_idle <= 4'($urandom);
        for (int i = 0; i < PWC_NCH; i++)
            m_prm[i] <= {1'($urandom), 15'($urandom_range(tp + 2, 0))};
        wb_xfer(1, PWC_OFF_MODE, 32'(md), 0);
        wb_xfer(1, PWC_OFF_PRESC, 32'(ps), 0);
        wb_xfer(1, PWC_OFF_LOAD, 32'(ld), 0);
        wb_xfer(1, PWC_OFF_TOP, 32'(tp), 0);
        wb_xfer(0, PWC_OFF_TOP, 0, 32'(tp));
        sequence_start_task <= 1'b1;
        @(posedge ref_clk);
        sequence_start_task <= 1'b0;
        settle_check(md, ps, (ld == PWC_LOAD_A) ? dt : tp);
        wb_xfer(1, PWC_OFF_TOP, 32'(tp2), 0);
        settle_check(md, ps, (ld == PWC_LOAD_A) ? dt : tp2);
        stop_task <= 1'b1;
        @(posedge ref_clk);
        stop_task <= 1'b0;
        @(posedge ref_clk iff halted_event === 1'b1);
        @(posedge ref_clk);
        cmp_idle();
    endtask
    // The longest run is far below this, so reaching it means a hang.
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        conclude();
    end
    initial
    begin
        void'($urandom(31949));
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        wb_xfer(0, PWC_OFF_TOP, 0, 32'(PWC_TOP_RST));
        wb_xfer(0, PWC_OFF_MODE, 0, 32'h0000_0000);
        wb_xfer(0, PWC_OFF_PRESC, 0, 32'h0000_0000);
        wb_xfer(0, 8'h14, 0, 32'h0000_0000);
        for (int k = 0; k < 8; k++)
            run_cfg(k % 2, $urandom_range(2, 0), (k / 2) % 2 ? 3 : 0, $urandom_range(20, 6), $urandom_range(20, 6));
        conclude();
    end
endmodule // tb
